// File: design/pdc_arbiter.v
`default_nettype none
`include "pdc_defines.vh"
module pdc_arbiter (
    input  wire       mclk_i,
    input  wire       reset_i,
    input  wire       dma_req_i,
    input  wire [2:0] dma_level_i,
    input  wire [2:0] cpl_i,
    input  wire       irq_req_i,
    input  wire [2:0] irq_level_i,
    input  wire       top_isr_i,
    input  wire       hold_i,
    output reg        dma_grant_o,
    output reg        irq_grant_o
);
    // Lower code is higher priority; equal allowed for DMA only
    function qualifies;
        input [2:0] lvl;
        input [2:0] current_priority_level;
        input       eq_ok;
        begin
            qualifies = eq_ok ? (lvl <= current_priority_level) : (lvl < current_priority_level);
        end
    endfunction

    reg  [2:0] tick;  // Sampling phase counter
    wire dma_ok = dma_req_i & ~top_isr_i & ~hold_i
                  & qualifies(dma_level_i, cpl_i, 1'b1);
    // Interrupts also wait while a transfer is held or running
    wire irq_ok = irq_req_i & ~hold_i
                  & qualifies(irq_level_i, cpl_i, 1'b0);

    // One shared arbitration phase every sample period
    always @(posedge mclk_i) begin
        if (reset_i) begin
            tick        <= 3'd0;
            dma_grant_o <= 1'b0;
            irq_grant_o <= 1'b0;
        end else begin
            dma_grant_o <= 1'b0;
            irq_grant_o <= 1'b0;
            if (tick == `PDC_SAMPLE_CYC - 3'd1) begin
                tick <= 3'd0;
                // Tie on level goes to DMA
                if (dma_ok && (!irq_ok ||
                    dma_level_i <= irq_level_i)) begin
                    dma_grant_o <= 1'b1;
                end else if (irq_ok) begin
                    irq_grant_o <= 1'b1;
                end
            end else begin
                tick <= tick + 3'd1;
            end
        end
    end
endmodule // pdc_arbiter
`default_nettype wire

// File: design/pdc_channel.v
// Implementation choices: register access over Wishbone and the address map.
`default_nettype none
`include "pdc_defines.vh"
module pdc_channel (
    input  wire        mclk_i,
    input  wire        reset_i,
    // Wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire        wb_ack_o,
    // Peripheral side
    input  wire        periph_event_i,
    input  wire        periph_to_store_i,
    input  wire [7:0]  periph_data_i,
    output reg  [7:0]  periph_data_o,
    output reg         periph_load_o,
    // CPU arbitration side
    input  wire [2:0]  cpl_i,
    input  wire        irq_req_i,
    input  wire [2:0]  irq_level_i,
    input  wire        top_isr_i,
    input  wire        instr_end_i,
    input  wire        eob_ack_i,
    output wire        irq_grant_o,
    output reg         dma_busy_o,
    output reg         eob_irq_o,
    output reg  [2:0]  eob_level_o,
    // Register file port
    input  wire [7:0]  rf_rdata_i,
    output reg  [7:0]  rf_addr_o,
    output reg  [7:0]  rf_wdata_o,
    output reg         rf_we_o,
    output reg         rf_re_o,
    // Memory port
    input  wire [7:0]  mem_rdata_i,
    input  wire        mem_ready_i,
    output reg         mem_req_o,
    output reg         mem_we_o,
    output reg  [15:0] mem_addr_o,
    output reg         mem_seg_o,
    output reg  [7:0]  mem_wdata_o
);
    // Software-visible state
    reg  [7:0]  counter_pointer_reg;  // Counter pointer, bit 0 space
    reg  [7:0]  address_pointer_reg;  // Address pointer, bit 0 segment
    reg         request_pending;      // Pending request
    reg         transfer_mask;        // Allows DMA requests
    reg         block_end_mask;       // Allows block-end interrupt
    reg  [2:0]  source_priority;      // 000 highest
    reg         swap_en;              // Two-table mode
    reg         table_sel;            // Table now in use
    reg         eob_flag;             // Block ended, not yet taken
    // Transfer engine state
    reg         armed;                // Granted, waiting for end
    reg         busy;                 // Transfer running
    reg  [3:0]  step;                 // Cycle inside the transfer
    reg         space_q;              // Space latched at start
    reg         dir_q;                // 1: peripheral to storage
    reg  [15:0] addr_d;               // Fetched address descriptor
    reg  [15:0] cnt_d;                // Fetched counter descriptor

    wire [3:0]  wr_hit;               // One-hot register write
    wire [31:0] rd_word;              // All registers for read
    wire        dma_grant;            // Acknowledge pulse

    // Pair base inside the register file for the active table
    function [7:0] desc_base;
        input [7:0] ptr;
        input       tbl;
        begin
            desc_base = {ptr[7:1], 1'b0}
                        + (tbl ? `PDC_TBL_STEP : 8'h00);
        end
    endfunction

    // Post step, cut to 8 bits outside memory mode
    function [15:0] step_word;
        input [15:0] v;
        input        wide;
        input        up;
        reg   [15:0] r;
        begin
            r = up ? v + 16'h0001 : v - 16'h0001;
            step_word = wide ? r : {8'h00, r[7:0]};
        end
    endfunction

    wire [7:0]  cbase = desc_base(counter_pointer_reg, table_sel);
    wire [7:0]  abase = desc_base(address_pointer_reg, table_sel);
    wire [7:0]  cnext = cbase + 8'h01;
    wire [7:0]  anext = abase + 8'h01;
    // Updated descriptors from the fetched values
    wire [15:0] next_addr = step_word(addr_d, ~space_q, 1'b1);
    wire [15:0] next_cnt  = step_word(cnt_d, ~space_q, 1'b0);
    wire        last_w    = (next_cnt == 16'h0000);
    // Final cycle of the transfer in either space
    wire        fin_w = busy && (step == (space_q ? `PDC_RF_LAST
                                                  : `PDC_MEM_LAST));

    assign rd_word = {4'h0, eob_flag, busy, table_sel, swap_en,
                      2'b00, request_pending, transfer_mask,
                      block_end_mask, source_priority,
                      address_pointer_reg, counter_pointer_reg};

    pdc_wb_slave u_bus (
        .mclk_i    (mclk_i),
        .reset_i   (reset_i),
        .wb_cyc_i  (wb_cyc_i),
        .wb_stb_i  (wb_stb_i),
        .wb_we_i   (wb_we_i),
        .wb_adr_i  (wb_adr_i),
        .wb_sel_i  (wb_sel_i),
        .rd_word_i (rd_word),
        .wb_ack_o  (wb_ack_o),
        .wb_dat_o  (wb_dat_o),
        .wr_hit_o  (wr_hit)
    );

    // Arbiter is held while armed or busy, so one at a time
    pdc_arbiter u_arb (
        .mclk_i      (mclk_i),
        .reset_i     (reset_i),
        .dma_req_i   (request_pending & transfer_mask),
        .dma_level_i (source_priority),
        .cpl_i       (cpl_i),
        .irq_req_i   (irq_req_i),
        .irq_level_i (irq_level_i),
        .top_isr_i   (top_isr_i),
        .hold_i      (armed | busy),
        .dma_grant_o (dma_grant),
        .irq_grant_o (irq_grant_o)
    );

    // Control and status bits; hardware set is applied last
    always @(posedge mclk_i) begin
        if (reset_i) begin
            counter_pointer_reg <= `PDC_RST_REG;
            address_pointer_reg <= `PDC_RST_REG;
            request_pending     <= 1'b0;
            transfer_mask       <= 1'b0;
            block_end_mask      <= 1'b0;
            source_priority     <= 3'b000;
            swap_en             <= 1'b0;
            table_sel           <= 1'b0;
            eob_flag            <= 1'b0;
            eob_irq_o           <= 1'b0;
            eob_level_o         <= 3'b000;
        end else begin
            if (wr_hit[0]) begin
                counter_pointer_reg <= wb_dat_i[7:0];
            end
            if (wr_hit[1]) begin
                address_pointer_reg <= wb_dat_i[7:0];
            end
            // Acknowledge drops the pending request
            if (dma_grant) begin
                request_pending <= 1'b0;
            end
            // Software may set or cancel the request itself
            if (wr_hit[2]) begin
                request_pending <= wb_dat_i[`PDC_CTRL_PEND];
                transfer_mask   <= wb_dat_i[`PDC_CTRL_MASK];
                block_end_mask  <= wb_dat_i[`PDC_CTRL_EOBM];
                source_priority <= wb_dat_i[2:0];
            end
            if (wr_hit[3]) begin
                swap_en <= wb_dat_i[`PDC_CFG_SWAP];
            end
            // Block-end flag: write one to clear, or CPU take
            if ((wr_hit[3] && wb_dat_i[`PDC_CFG_EOB]) || eob_ack_i) begin
                eob_flag <= 1'b0;
            end
            // Back to table 0 once swapping stops and idle
            if (!swap_en && !busy) begin
                table_sel <= 1'b0;
            end
            // Block end: swap tables or close the channel
            if (fin_w && last_w) begin
                eob_flag <= 1'b1;
                if (swap_en) begin
                    table_sel <= ~table_sel;
                end else begin
                    transfer_mask <= 1'b0;
                end
            end
            // A trigger in the clearing cycle is not lost
            if (periph_event_i) begin
                request_pending <= 1'b1;
            end
            // Interrupt gated by the block-end mask
            eob_irq_o <= block_end_mask & (eob_flag |
                         (request_pending & ~transfer_mask));
            eob_level_o <= source_priority;
        end
    end

    // Transfer engine; fixed step schedule per space
    always @(posedge mclk_i) begin
        if (reset_i) begin
            armed         <= 1'b0;
            busy          <= 1'b0;
            dma_busy_o    <= 1'b0;
            step          <= 4'd0;
            space_q       <= 1'b0;
            dir_q         <= 1'b0;
            addr_d        <= 16'h0000;
            cnt_d         <= 16'h0000;
            periph_data_o <= 8'h00;
            periph_load_o <= 1'b0;
            rf_addr_o     <= 8'h00;
            rf_wdata_o    <= 8'h00;
            rf_we_o       <= 1'b0;
            rf_re_o       <= 1'b0;
            mem_req_o     <= 1'b0;
            mem_we_o      <= 1'b0;
            mem_addr_o    <= 16'h0000;
            mem_seg_o     <= 1'b0;
            mem_wdata_o   <= 8'h00;
        end else begin
            // Strobes default low each cycle
            rf_we_o       <= 1'b0;
            rf_re_o       <= 1'b0;
            periph_load_o <= 1'b0;
            if (dma_grant) begin
                armed <= 1'b1;
            end
            if (!busy) begin
                // Start only between instructions
                if (armed && instr_end_i) begin
                    armed      <= 1'b0;
                    busy       <= 1'b1;
                    dma_busy_o <= 1'b1;
                    step       <= 4'd0;
                    space_q    <= counter_pointer_reg[0];
                    dir_q      <= periph_to_store_i;
                    mem_seg_o  <= address_pointer_reg[0];
                end
            end else begin
                step <= step + 4'd1;
                if (space_q) begin
                    // Register space: address even, counter odd
                    case (step)
                        4'd0: begin
                            rf_addr_o <= cbase;
                            rf_re_o   <= 1'b1;
                        end
                        4'd1: begin
                            rf_addr_o <= cnext;
                            rf_re_o   <= 1'b1;
                        end
                        4'd2: begin
                            addr_d <= {8'h00, rf_rdata_i};
                        end
                        4'd3: begin
                            cnt_d     <= {8'h00, rf_rdata_i};
                            rf_addr_o <= addr_d[7:0];
                            if (dir_q) begin
                                rf_wdata_o    <= periph_data_i;
                                rf_we_o       <= 1'b1;
                                periph_load_o <= 1'b1;
                            end else begin
                                rf_re_o <= 1'b1;
                            end
                        end
                        4'd4: begin
                            rf_addr_o  <= cbase;
                            rf_wdata_o <= next_addr[7:0];
                            rf_we_o    <= 1'b1;
                        end
                        4'd5: begin
                            if (!dir_q) begin
                                periph_data_o <= rf_rdata_i;
                                periph_load_o <= 1'b1;
                            end
                            rf_addr_o  <= cnext;
                            rf_wdata_o <= next_cnt[7:0];
                            rf_we_o    <= 1'b1;
                        end
                        `PDC_RF_LAST: begin
                            busy       <= 1'b0;
                            dma_busy_o <= 1'b0;
                            step       <= 4'd0;
                        end
                        default: begin
                        end
                    endcase
                end else begin
                    // Memory space: 16-bit pairs, high byte even
                    case (step)
                        4'd0: begin
                            rf_addr_o <= cbase;
                            rf_re_o   <= 1'b1;
                        end
                        4'd1: begin
                            rf_addr_o <= cnext;
                            rf_re_o   <= 1'b1;
                        end
                        4'd2: begin
                            cnt_d[15:8] <= rf_rdata_i;
                            rf_addr_o   <= abase;
                            rf_re_o     <= 1'b1;
                        end
                        4'd3: begin
                            cnt_d[7:0] <= rf_rdata_i;
                            rf_addr_o  <= anext;
                            rf_re_o    <= 1'b1;
                        end
                        4'd4: begin
                            addr_d[15:8] <= rf_rdata_i;
                        end
                        4'd5: begin
                            addr_d[7:0] <= rf_rdata_i;
                        end
                        4'd6: begin
                            mem_req_o   <= 1'b1;
                            mem_we_o    <= dir_q;
                            mem_addr_o  <= addr_d;
                            mem_wdata_o <= periph_data_i;
                            if (dir_q) begin
                                periph_load_o <= 1'b1;
                            end
                        end
                        4'd7: begin
                            // Wait states stretch the transfer
                            if (!mem_ready_i) begin
                                step <= step;
                            end else begin
                                mem_req_o <= 1'b0;
                                mem_we_o  <= 1'b0;
                                if (!dir_q) begin
                                    periph_data_o <= mem_rdata_i;
                                    periph_load_o <= 1'b1;
                                end
                            end
                        end
                        4'd8: begin
                            rf_addr_o  <= abase;
                            rf_wdata_o <= next_addr[15:8];
                            rf_we_o    <= 1'b1;
                        end
                        4'd9: begin
                            rf_addr_o  <= anext;
                            rf_wdata_o <= next_addr[7:0];
                            rf_we_o    <= 1'b1;
                        end
                        4'd10: begin
                            rf_addr_o  <= cbase;
                            rf_wdata_o <= next_cnt[15:8];
                            rf_we_o    <= 1'b1;
                        end
                        4'd11: begin
                            rf_addr_o  <= cnext;
                            rf_wdata_o <= next_cnt[7:0];
                            rf_we_o    <= 1'b1;
                        end
                        `PDC_MEM_LAST: begin
                            busy       <= 1'b0;
                            dma_busy_o <= 1'b0;
                            step       <= 4'd0;
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
    end
endmodule // pdc_channel
`default_nettype wire

// File: design/pdc_defines.vh
`ifndef PDC_DEFINES_VH
`define PDC_DEFINES_VH

// Register byte addresses on the bus
`define PDC_OFF_CPTR   8'h00
`define PDC_OFF_APTR   8'h04
`define PDC_OFF_CTRL   8'h08
`define PDC_OFF_CFG    8'h0c
// Control register fields
`define PDC_CTRL_PEND  5
`define PDC_CTRL_MASK  4
`define PDC_CTRL_EOBM  3
// Configuration and status fields
`define PDC_CFG_SWAP   0
`define PDC_CFG_TBL    1
`define PDC_CFG_BUSY   2
`define PDC_CFG_EOB    3
// Reset value of every register
`define PDC_RST_REG    8'h00
// Timing counts in core clock cycles
`define PDC_SAMPLE_CYC 3'd5
`define PDC_RF_LAST    4'd7
`define PDC_MEM_LAST   4'd15
// Distance from table 0 to table 1 descriptors
`define PDC_TBL_STEP   8'h02
`endif

// File: design/pdc_wb_slave.v
`default_nettype none
`include "pdc_defines.vh"
module pdc_wb_slave (
    input  wire        mclk_i,
    input  wire        reset_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] rd_word_i,
    output reg         wb_ack_o,
    output reg  [31:0] wb_dat_o,
    output wire [3:0]  wr_hit_o
);
    // Decode to {valid, index}; misaligned addresses are unmapped
    function [2:0] reg_index;
        input [7:0] a;
        begin
            case (a)
                `PDC_OFF_CPTR: reg_index = 3'b100;
                `PDC_OFF_APTR: reg_index = 3'b101;
                `PDC_OFF_CTRL: reg_index = 3'b110;
                `PDC_OFF_CFG:  reg_index = 3'b111;
                default:       reg_index = 3'b000;
            endcase
        end
    endfunction

    wire [2:0] idx   = reg_index(wb_adr_i);  // Current decode
    wire       wr_ok = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i
                       & wb_sel_i[0] & idx[2];

    // Write lands only on the edge where ack is high
    assign wr_hit_o = wr_ok ? (4'b0001 << idx[1:0]) : 4'b0000;

    // Ack one cycle after request, dropped the cycle after
    always @(posedge mclk_i) begin
        if (reset_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            if (wb_cyc_i && wb_stb_i && !wb_ack_o && idx[2]) begin
                // Narrow register in the low byte, rest zero
                wb_dat_o <= {24'h00_0000,
                             rd_word_i[{idx[1:0], 3'b000} +: 8]};
            end else begin
                // Unmapped reads answer zero
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end
endmodule // pdc_wb_slave
`default_nettype wire

// File: testbench/pdc_channel_assertions.sv
`default_nettype none
module pdc_channel_chk (
    input wire logic        mclk_i,
    input wire logic        reset_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic        irq_grant_o,
    input wire logic        dma_busy_o,
    input wire logic        periph_load_o,
    input wire logic        rf_re_o,
    input wire logic        mem_req_o,
    input wire logic        mem_ready_i,
    input wire logic [15:0] mem_addr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    ack_one_cycle_a: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single pulse one cycle after request");
    read_upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 0)
        else $error("upper read bits not zero");
    busy_min_len_a: assert property (
        $rose(dma_busy_o) |-> dma_busy_o [*8])
        else $error("transfer shorter than eight cycles");
    grant_spacing_a: assert property (
        irq_grant_o |=> !irq_grant_o [*4])
        else $error("grants closer than the sampling period");
    no_irq_in_dma_a: assert property (dma_busy_o |-> !irq_grant_o)
        else $error("interrupt granted during a transfer");
    fetch_in_busy_a: assert property (rf_re_o |-> dma_busy_o)
        else $error("descriptor read outside a transfer");
    load_in_busy_a: assert property (periph_load_o |-> dma_busy_o)
        else $error("peripheral access outside a transfer");
    mem_hold_a: assert property (
        mem_req_o && !mem_ready_i |=> mem_req_o && $stable(mem_addr_o))
        else $error("memory request dropped before ready");
endmodule // pdc_channel_chk
`default_nettype wire

// File: testbench/pdc_far_model.sv
`default_nettype none
module pdc_far_model (
    input  wire logic        mclk_i,
    input  wire logic [7:0]  rf_addr_i,
    input  wire logic [7:0]  rf_wdata_i,
    input  wire logic        rf_we_i,
    input  wire logic        rf_re_i,
    input  wire logic        mem_req_i,
    input  wire logic [15:0] mem_addr_i,
    input  wire logic        mem_seg_i,
    input  wire logic [1:0]  waits_i,
    output logic      [7:0]  rf_rdata_o,
    output logic      [7:0]  mem_rdata_o,
    output logic             mem_ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rf [0:255];  // Register file image
    logic [7:0] mem [0:255]; // Memory image, low address byte only
    logic [1:0] wcnt = 0;    // Wait states served so far
    logic       seg_seen;    // Segment select seen at the data phase
    initial rf_rdata_o = 8'h00;
    // Ready after the asked wait states; data scrambled while not ready
    assign mem_ready_o = mem_req_i && wcnt == waits_i;
    assign mem_rdata_o = mem_ready_o ? mem[mem_addr_i[7:0]] : {4{wcnt}};
    // Read data lands one cycle after the strobe, else it keeps changing
    always @(posedge mclk_i) begin
        rf_rdata_o <= rf_re_i ? rf[rf_addr_i] : ~rf_rdata_o;
        if (rf_we_i)
            rf[rf_addr_i] <= rf_wdata_i;
        wcnt <= (mem_req_i && !mem_ready_o) ? wcnt + 2'd1 : 2'd0;
        if (mem_ready_o)
            seg_seen <= mem_seg_i;
    end
endmodule // pdc_far_model
`default_nettype wire

// File: testbench/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 0, reset_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [7:0] wb_adr_i = 0, periph_data_i = 8'ha5, q;
    logic [3:0] wb_sel_i = 4'h1;
    logic [31:0] wb_dat_i = 0, wb_dat_o;
    logic periph_event_i = 0, periph_to_store_i = 1, irq_req_i = 0;
    logic top_isr_i = 0, instr_end_i = 1, eob_ack_i = 0, wb_ack_o;
    logic [2:0] cpl_i = 3'h2, irq_level_i = 3'h1, eob_level_o;
    logic periph_load_o, irq_grant_o, dma_busy_o, eob_irq_o, mem_seg_o;
    logic rf_we_o, rf_re_o, mem_ready_i, mem_req_o, mem_we_o;
    logic [7:0] periph_data_o, rf_rdata_i, rf_addr_o, rf_wdata_o;
    logic [7:0] mem_rdata_i, mem_wdata_o;
    logic [15:0] mem_addr_o;
    logic [1:0] waits = 0;
    int n_errors = 0, num_checks = 0;
    pdc_channel pdc_channel_inst (.*);
    pdc_far_model pdc_far_model_inst (.mclk_i, .rf_addr_i(rf_addr_o),
        .rf_wdata_i(rf_wdata_o), .rf_we_i(rf_we_o), .rf_re_i(rf_re_o),
        .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o),
        .mem_seg_i(mem_seg_o), .waits_i(waits), .rf_rdata_o(rf_rdata_i),
        .mem_rdata_o(mem_rdata_i), .mem_ready_o(mem_ready_i));
    always #12.5 mclk_i = ~mclk_i;
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Classic single cycle: hold everything until ack is sampled
    task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        // Waits as long as it takes; only the watchdog ends a hang
        do @(posedge mclk_i);
        while (wb_ack_o !== 1'b1);
        q = wb_dat_o[7:0];
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
        @(posedge mclk_i);
    endtask
    task automatic rd(input string nm, input logic [7:0] a, exp);
        wb(a, 1'b0, 8'h00);
        chk(nm, {24'h0, q}, {24'h0, exp});
    endtask
    task automatic fire();
        periph_event_i <= 1;
        @(posedge mclk_i);
        periph_event_i <= 0;
    endtask
    // Waits for a transfer, then counts its busy cycles
    task automatic xfer(input int exp);
        int n, len;
        n = 0;
        len = 0;
        while (dma_busy_o !== 1'b1 && n < 200) begin
            @(posedge mclk_i);
            n++;
        end
        while (dma_busy_o === 1'b1 && len < 100) begin
            @(posedge mclk_i);
            len++;
        end
        chk("busy cycles", len, exp);
    endtask
    task automatic complete_run();
        $display("Checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #150us;
        n_errors++;
        complete_run();
    end
    initial begin
        repeat (2) @(posedge mclk_i);
        reset_i <= 0;
        @(posedge mclk_i);
        rd("cnt ptr", 8'h00, 8'h00);
        rd("cfg", 8'h0c, 8'h00);
        rd("unmapped", 8'h40, 8'h00);
        pdc_far_model_inst.rf[8'h20] = 8'h40;
        pdc_far_model_inst.rf[8'h21] = 8'h02;
        wb(8'h00, 1'b1, 8'h21);
        wb(8'h08, 1'b1, 8'h1b);
        fire();
        repeat (20) @(posedge mclk_i);
        rd("refused", 8'h08, 8'h3b);
        cpl_i <= 3'h3;
        top_isr_i <= 1;
        repeat (20) @(posedge mclk_i);
        rd("top isr", 8'h08, 8'h3b);
        top_isr_i <= 0;
        xfer(8);
        chk("rf data", pdc_far_model_inst.rf[8'h40], 8'ha5);
        chk("rf addr", pdc_far_model_inst.rf[8'h20], 8'h41);
        chk("rf cnt", pdc_far_model_inst.rf[8'h21], 8'h01);
        rd("ctrl", 8'h08, 8'h1b);
        fire();
        xfer(8);
        rd("ctrl", 8'h08, 8'h0b);
        chk("eob irq", eob_irq_o, 1);
        chk("eob level", eob_level_o, 3);
        pdc_far_model_inst.rf[8'h30] = 8'h00;
        pdc_far_model_inst.rf[8'h31] = 8'h01;
        pdc_far_model_inst.rf[8'h34] = 8'h12;
        pdc_far_model_inst.rf[8'h35] = 8'h34;
        pdc_far_model_inst.mem[8'h34] = 8'h5c;
        periph_to_store_i <= 0;
        waits <= 2'd2;
        wb(8'h00, 1'b1, 8'h30);
        wb(8'h04, 1'b1, 8'h35);
        wb(8'h08, 1'b1, 8'h1b);
        fire();
        xfer(18);
        chk("seg", pdc_far_model_inst.seg_seen, 1);
        chk("to periph", periph_data_o, 8'h5c);
        chk("mem addr", pdc_far_model_inst.rf[8'h35], 8'h35);
        chk("mem cnt", pdc_far_model_inst.rf[8'h31], 8'h00);
        rd("ctrl", 8'h08, 8'h0b);
        wb(8'h00, 1'b1, 8'h21);
        wb(8'h0c, 1'b1, 8'h09);
        pdc_far_model_inst.rf[8'h21] = 8'h01;
        pdc_far_model_inst.rf[8'h22] = 8'h50;
        pdc_far_model_inst.rf[8'h23] = 8'h01;
        periph_to_store_i <= 1;
        wb(8'h08, 1'b1, 8'h1b);
        fire();
        xfer(8);
        rd("swap ctrl", 8'h08, 8'h1b);
        rd("swap cfg", 8'h0c, 8'h0b);
        fire();
        xfer(8);
        chk("tbl1 data", pdc_far_model_inst.rf[8'h50], 8'ha5);
        rd("swap back", 8'h0c, 8'h09);
        irq_req_i <= 1;
        for (int i = 0; i < 10 && irq_grant_o !== 1'b1; i++)
            @(posedge mclk_i);
        chk("irq grant", irq_grant_o, 1);
        irq_req_i <= 0;
        complete_run();
    end
endmodule // tb_top
bind pdc_channel pdc_channel_chk pdc_channel_chk_inst (.*);
`default_nettype wire
